// File: logic/sff_pkg.sv
// Shared constants and carrier types for the flash service sequencer.
// Assumes one 10 MHz clock; SRAM and flash ports are on that same clock.
`default_nettype none
package sff_pkg;
   // Function codes taken from the accumulator on a call
   localparam logic [7:0] FN_BOOT    = 8'h00;
   localparam logic [7:0] FN_FETCH   = 8'h01;
   localparam logic [7:0] FN_PROGRAM = 8'h02;
   localparam logic [7:0] FN_CLEAR   = 8'h03;
   localparam logic [7:0] FN_LOCK    = 8'h04;
   localparam logic [7:0] FN_WIPE    = 8'h05;
   // Parameter block in SRAM
   localparam logic [7:0] PB_BASE    = 8'hF8;
   localparam int         PB_WORDS   = 7;
   localparam int         PB_FIRST_GUARD_KEY    = 0;
   localparam int         PB_SECOND_GUARD_KEY    = 1;
   localparam int         PB_ROW     = 2;
   localparam int         PB_PTR     = 3;
   localparam int         PB_CLK     = 4;
   localparam int         PB_DLY     = 6;
   localparam logic [7:0] PB_FIRST_GUARD_KEY_AT = 8'hF8;
   localparam logic [7:0] PB_SECOND_GUARD_KEY_AT = 8'hF9;
   localparam logic [7:0] FIRST_GUARD_KEY_VALUE = 8'h3A;
   localparam logic [7:0] SECOND_GUARD_KEY_BIAS  = 8'h03;
   localparam logic [7:0] LOCK_SRC   = 8'h80;
   // Result codes
   localparam logic [7:0] RC_OK      = 8'h00;
   localparam logic [7:0] RC_REFUSED = 8'h01;
   localparam logic [7:0] RC_SWBOOT  = 8'h02;
   localparam logic [7:0] RC_FATAL   = 8'h03;
   localparam logic [7:0] ACC_RESET  = 8'h00;
   // Protection levels
   localparam logic [1:0] PL_OPEN    = 2'h0;
   localparam logic [1:0] PL_NOREAD  = 2'h1;
   localparam logic [1:0] PL_NOEXTWR = 2'h2;
   localparam logic [1:0] PL_FULL    = 2'h3;
   // Flash geometry: bit 13 selects the hidden rows
   localparam int          ROW_BYTES = 64;
   localparam logic [5:0]  ROW_LAST  = 6'h3F;
   localparam logic [13:0] PROT_ROW  = 14'h2000;
   localparam logic [13:0] CAL_ROW   = 14'h2040;
   localparam logic [5:0]  CAL_SUM_N = 6'h3D;
   localparam logic [5:0]  CAL_LO_AT = 6'h3E;
   // Software register indexes
   localparam logic [1:0] RG_STATUS  = 2'h0;
   localparam logic [1:0] RG_RESULT  = 2'h1;
   localparam logic [1:0] RG_LASTFN  = 2'h2;
   localparam logic [1:0] RG_CTRL    = 2'h3;
   localparam int         CTRL_RESUME = 0;

   typedef enum logic [2:0] {
      FL_NONE, FL_READ, FL_PROG_BYTE, FL_ERASE_ROW,
      FL_ERASE_USER, FL_ZERO_USER, FL_ZERO_ROW
   } sff_flop_t;

   typedef struct packed {
      sff_flop_t   op;
      logic [13:0] addr;
      logic [7:0]  wdata;
   } sff_flash_cmd_t;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sff_sram_req_t;

   // Two-bit level of a row within its packed protection byte
   function automatic logic [1:0] sff_level(input logic [7:0] b, input logic [1:0] sel);
      sff_level = 2'((b >> {sel, 1'b0}) & 8'h03);
   endfunction : sff_level

   // User-space flash address of one byte of a row
   function automatic logic [13:0] sff_row_addr(input logic [7:0] row, input logic [5:0] i);
      sff_row_addr = {1'b0, row[6:0], i};
   endfunction : sff_row_addr
endpackage : sff_pkg
`default_nettype wire

// File: logic/sff_pulse_timer.sv
// Flash pulse timer: width is (divider+1) x (delay+1) clock cycles.
// Assumes start is a one-cycle pulse issued only while idle.
`default_nettype none
`timescale 1ns/1ps
module sff_pulse_timer
   import sff_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   // Control
   input  wire logic       start_in,
   input  wire logic [7:0] div_in,
   input  wire logic [7:0] dly_in,
   // Completion
   output var  logic       done_out
);
   logic       run_r;
   logic [7:0] div_cnt_r;
   logic [7:0] dly_cnt_r;
   logic       tick;

   // One-cycle enable from the divider, the slow pulse rate
   assign tick = run_r && (div_cnt_r == 8'h00);

   // Divider restarts on every enable
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_cnt_r <= 8'h00;
      end else if (start_in || tick) begin
         div_cnt_r <= div_in;
      end else if (run_r) begin
         div_cnt_r <= div_cnt_r - 8'h01;
      end
   end

   // Counts enables; a zero divider and delay still give one cycle
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_r     <= 1'b0;
         dly_cnt_r <= 8'h00;
         done_out  <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            run_r     <= 1'b1;
            dly_cnt_r <= dly_in;
         end else if (tick) begin
            if (dly_cnt_r == 8'h00) begin
               run_r    <= 1'b0;
               done_out <= 1'b1;
            end else begin
               dly_cnt_r <= dly_cnt_r - 8'h01;
            end
         end
      end
   end
endmodule : sff_pulse_timer
`default_nettype wire

// File: logic/sff_sequencer.sv
// Flash service sequencer: runs one supervisory function per call.
// Assumes SRAM and flash read data stand while the registered request stands.
`default_nettype none
`timescale 1ns/1ps
module sff_sequencer
   import sff_pkg::*;
(
   // Clock and reset
   input  wire logic           mclk_in,
   input  wire logic           rst_n_in,
   // Processor call port
   input  wire logic           call_in,
   input  wire logic [7:0]     acc_in,
   input  wire logic [7:0]     sp_in,
   output var  logic [7:0]     acc_out,
   output var  logic           release_out,
   output var  logic           halt_out,
   output var  logic           busy_out,
   // SRAM port
   output var  sff_sram_req_t  sram_out,
   input  wire logic [7:0]     sram_rdata_in,
   // Flash port
   output var  sff_flash_cmd_t flash_out,
   input  wire logic [7:0]     flash_rdata_in,
   // Register port
   input  wire logic [1:0]     reg_addr_in,
   input  wire logic [7:0]     reg_wdata_in,
   input  wire logic           reg_we_in,
   input  wire logic           reg_re_in,
   output var  logic [7:0]     reg_rdata_out
);
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000, ST_PARAM = 4'b0001, ST_CHECK = 4'b0011,
      ST_PROT  = 4'b0010, ST_RD    = 4'b0110, ST_CAP   = 4'b0111,
      ST_WAIT  = 4'b0101, ST_PULSE = 4'b0100, ST_PWAIT = 4'b1100,
      ST_WB1   = 4'b1101, ST_WB2   = 4'b1111, ST_DONE  = 4'b1110,
      ST_HALT  = 4'b1010, ST_BOOT  = 4'b1011
   } sff_state_t;

   sff_state_t  state_r;
   logic [7:0]  fn_r;
   logic [7:0]  sp_r;
   logic [7:0]  par_r [PB_WORDS];
   logic [2:0]  pidx_r;
   logic [5:0]  idx_r;
   logic [2:0]  step_r;
   logic [7:0]  rc_r;
   logic        fatal_r;
   logic        soft_r;
   logic [15:0] sum_r;
   logic [7:0]  cal_lo_r;
   logic        tstart_r;
   logic        tdone;
   logic [1:0]  level;
   logic        refuse;
   logic        keys_ok;
   logic        fn_known;
   logic [7:0]  lock_byte;

   sff_pulse_timer u_timer (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .start_in (tstart_r),
      .div_in   (par_r[PB_CLK]),
      .dly_in   (par_r[PB_DLY]),
      .done_out (tdone)
   );

   // Decodes used by the check and protection states
   assign keys_ok  = (par_r[PB_FIRST_GUARD_KEY] == FIRST_GUARD_KEY_VALUE) &&
                     (par_r[PB_SECOND_GUARD_KEY] == 8'(sp_r + SECOND_GUARD_KEY_BIAS));
   assign fn_known = (fn_r >= FN_FETCH) && (fn_r <= FN_WIPE);
   assign level    = sff_level(flash_rdata_in, par_r[PB_ROW][1:0]);
   // Fetch refused for no-read and full; program and clear only for full
   assign refuse   = (fn_r == FN_FETCH) ? (level == PL_NOREAD || level == PL_FULL)
                                        : (level == PL_FULL);
   assign lock_byte = flash_rdata_in | sram_rdata_in;

   // Main sequence; one call at a time, busy until release or halt
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r  <= ST_BOOT;
         fn_r     <= FN_BOOT;
         sp_r     <= 8'h00;
         pidx_r   <= 3'h0;
         idx_r    <= 6'h00;
         step_r   <= 3'h0;
         rc_r     <= RC_OK;
         fatal_r  <= 1'b0;
         soft_r   <= 1'b0;
         tstart_r <= 1'b0;
         for (int k = 0; k < PB_WORDS; k++) begin
            par_r[k] <= 8'h00;
         end
      end else begin
         tstart_r <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               if (call_in) begin
                  fn_r   <= acc_in;
                  sp_r   <= sp_in;
                  pidx_r <= 3'h0;
                  soft_r <= 1'b1;
                  // Boot needs no parameters and no keys
                  state_r <= (acc_in == FN_BOOT) ? ST_BOOT : ST_PARAM;
               end
            end
            ST_BOOT: begin
               idx_r   <= 6'h00;
               sum_r   <= 16'h0000;
               fatal_r <= 1'b0;
               state_r <= ST_RD;
            end
            ST_PARAM: begin
               // Reads lead the capture by one cycle
               pidx_r <= pidx_r + 3'h1;
               if (pidx_r != 3'h0) begin
                  par_r[pidx_r - 3'h1] <= sram_rdata_in;
               end
               if (pidx_r == 3'(PB_WORDS)) begin
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               idx_r  <= 6'h00;
               step_r <= 3'h0;
               if (!keys_ok || !fn_known) begin
                  state_r <= ST_HALT;
               end else if (fn_r == FN_WIPE) begin
                  state_r <= ST_PULSE;
               end else if (fn_r == FN_LOCK) begin
                  state_r <= ST_RD;
               end else begin
                  state_r <= ST_PROT;
               end
            end
            ST_PROT: begin
               if (refuse) begin
                  rc_r    <= RC_REFUSED;
                  state_r <= ST_WB1;
               end else begin
                  state_r <= (fn_r == FN_CLEAR) ? ST_PULSE : ST_RD;
               end
            end
            ST_RD: begin
               state_r <= ST_CAP;
            end
            ST_CAP: begin
               if (fn_r == FN_PROGRAM || fn_r == FN_LOCK) begin
                  tstart_r <= 1'b1;
                  state_r  <= ST_WAIT;
               end else begin
                  if (fn_r == FN_BOOT) begin
                     if (idx_r <= CAL_SUM_N) begin
                        sum_r <= sum_r + {8'h00, flash_rdata_in};
                     end
                     if (idx_r == CAL_LO_AT) begin
                        cal_lo_r <= flash_rdata_in;
                     end
                     if (idx_r == ROW_LAST) begin  // Last byte only stands here
                        fatal_r <= (sum_r != {flash_rdata_in, cal_lo_r});
                     end
                  end
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Program pulses must finish before the next byte
               if (tdone || !(fn_r == FN_PROGRAM || fn_r == FN_LOCK)) begin
                  idx_r <= idx_r + 6'h01;
                  if (idx_r != ROW_LAST) begin
                     state_r <= ST_RD;
                  end else if (fn_r == FN_BOOT) begin
                     if (fatal_r) begin
                        rc_r    <= RC_FATAL;
                        state_r <= ST_WB1;
                     end else begin
                        rc_r    <= RC_SWBOOT;
                        state_r <= soft_r ? ST_WB1 : ST_DONE;
                     end
                  end else begin
                     rc_r    <= RC_OK;
                     state_r <= ST_WB1;
                  end
               end
            end
            ST_PULSE: begin
               tstart_r <= 1'b1;
               state_r  <= ST_PWAIT;
            end
            ST_PWAIT: begin
               if (tdone) begin
                  step_r <= step_r + 3'h1;
                  // Clear is one pulse; wipe is five
                  if (fn_r == FN_WIPE && step_r != 3'h4) begin
                     state_r <= ST_PULSE;
                  end else begin
                     rc_r    <= RC_OK;
                     state_r <= ST_WB1;
                  end
               end
            end
            ST_WB1: begin
               state_r <= (fn_r == FN_BOOT) ? ST_DONE : ST_WB2;
            end
            ST_WB2: begin
               state_r <= ST_DONE;
            end
            ST_DONE: begin
               state_r <= fatal_r ? ST_HALT : ST_IDLE;
            end
            ST_HALT: begin
               if (reg_we_in && reg_addr_in == RG_CTRL && reg_wdata_in[CTRL_RESUME]) begin
                  fatal_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_HALT;
            end
         endcase
      end
   end

   // SRAM requests: parameter reads, data moves, result writes
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sram_out <= '0;
      end else begin
         sram_out <= '0;
         if (state_r == ST_PARAM && pidx_r < 3'(PB_WORDS)) begin
            sram_out.re   <= 1'b1;
            sram_out.addr <= PB_BASE + {5'h00, pidx_r};
         end else if (state_r == ST_RD && fn_r == FN_PROGRAM) begin
            sram_out.re   <= 1'b1;
            sram_out.addr <= par_r[PB_PTR] + {2'h0, idx_r};
         end else if (state_r == ST_RD && fn_r == FN_LOCK) begin
            sram_out.re   <= 1'b1;
            sram_out.addr <= LOCK_SRC + {2'h0, idx_r};
         end else if (state_r == ST_CAP && fn_r == FN_FETCH) begin
            sram_out.we    <= 1'b1;
            sram_out.addr  <= par_r[PB_PTR] + {2'h0, idx_r};
            sram_out.wdata <= flash_rdata_in;
         end else if (state_r == ST_WB1) begin
            sram_out.we    <= 1'b1;
            sram_out.addr  <= PB_FIRST_GUARD_KEY_AT;
            sram_out.wdata <= rc_r;
         end else if (state_r == ST_WB2) begin
            sram_out.we    <= 1'b1;
            sram_out.addr  <= PB_SECOND_GUARD_KEY_AT;
            sram_out.wdata <= 8'h00;
         end
      end
   end

   // Flash commands; pulse commands are held until the timer ends
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flash_out <= '0;
      end else if (state_r == ST_CHECK && fn_known && fn_r != FN_LOCK && fn_r != FN_WIPE) begin
         flash_out <= '{FL_READ, PROT_ROW + {8'h00, par_r[PB_ROW][7:2]}, 8'h00};
      end else if (state_r == ST_RD) begin
         unique case (fn_r)
            FN_FETCH: flash_out <= '{FL_READ, sff_row_addr(par_r[PB_ROW], idx_r), 8'h00};
            FN_LOCK:  flash_out <= '{FL_READ, PROT_ROW + {8'h00, idx_r}, 8'h00};
            FN_BOOT:  flash_out <= '{FL_READ, CAL_ROW + {8'h00, idx_r}, 8'h00};
            default:  flash_out <= '0;
         endcase
      end else if (state_r == ST_CAP && fn_r == FN_PROGRAM) begin
         flash_out <= '{FL_PROG_BYTE, sff_row_addr(par_r[PB_ROW], idx_r), sram_rdata_in};
      end else if (state_r == ST_CAP && fn_r == FN_LOCK) begin
         flash_out <= '{FL_PROG_BYTE, PROT_ROW + {8'h00, idx_r}, lock_byte};
      end else if (state_r == ST_PULSE && fn_r == FN_CLEAR) begin
         // User row only; its protection byte is never touched
         flash_out <= '{FL_ERASE_ROW, sff_row_addr(par_r[PB_ROW], 6'h00), 8'h00};
      end else if (state_r == ST_PULSE) begin
         // Hidden rows above the protection row are never addressed
         unique case (step_r)
            3'h0, 3'h2: flash_out <= '{FL_ERASE_USER, 14'h0000, 8'h00};
            3'h1:       flash_out <= '{FL_ZERO_USER, 14'h0000, 8'h00};
            3'h3:       flash_out <= '{FL_ERASE_ROW, PROT_ROW, 8'h00};
            default:    flash_out <= '{FL_ZERO_ROW, PROT_ROW, 8'h00};
         endcase
      end else if (state_r == ST_CAP || tdone) begin
         flash_out <= '0;
      end else if (flash_out.op == FL_READ) begin
         flash_out <= '0;
      end
   end

   // Processor-facing outputs
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_out     <= ACC_RESET;
         release_out <= 1'b0;
         halt_out    <= 1'b0;
         busy_out    <= 1'b1;
      end else begin
         release_out <= (state_r == ST_DONE) && !fatal_r;
         halt_out    <= (state_r == ST_HALT) || (state_r == ST_DONE && fatal_r);
         busy_out    <= !(state_r == ST_IDLE || state_r == ST_HALT) || call_in;
         if (state_r == ST_WB1) begin
            acc_out <= 8'h00;
         end
      end
   end

   // Register read port; data stands in the cycle after the strobe
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_re_in) begin
         unique case (reg_addr_in)
            RG_STATUS: reg_rdata_out <= {5'h00, fatal_r, state_r == ST_HALT,
                                         state_r != ST_IDLE && state_r != ST_HALT};
            RG_RESULT: reg_rdata_out <= rc_r;
            RG_LASTFN: reg_rdata_out <= fn_r;
            RG_CTRL:   reg_rdata_out <= 8'h00;
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end
endmodule : sff_sequencer
`default_nettype wire

// File: verification/sff_sequencer_properties.sv
// Checker for the sequencer's call, halt and flash ports.
// Assumes one clock domain; bound to the sequencer from the bench top.
`timescale 1ns/1ps
`default_nettype none
module sff_sequencer_properties
   import sff_pkg::*;
(
   // Clock and reset
   input  wire logic           mclk_in,
   input  wire logic           rst_n_in,
   // Call port
   input  wire logic           call_in,
   input  wire logic [7:0]     acc_out,
   input  wire logic           release_out,
   input  wire logic           halt_out,
   input  wire logic           busy_out,
   input  wire sff_flash_cmd_t flash_out,
   // Register port
   input  wire logic [1:0]     reg_addr_in,
   input  wire logic [7:0]     reg_wdata_in,
   input  wire logic           reg_we_in
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // Reset release starts boot with a clear accumulator
   property p_boot_acc; $rose(rst_n_in) |-> acc_out == 8'h00; endproperty
   a_boot_acc: assert property (p_boot_acc) else $error("acc not clear at boot");
   property p_boot_busy; $rose(rst_n_in) |-> busy_out ##1 busy_out; endproperty
   a_boot_busy: assert property (p_boot_busy) else $error("boot not running");
   // A halted processor is never released
   property p_halt_quiet; halt_out |-> !release_out; endproperty
   a_halt_quiet: assert property (p_halt_quiet) else $error("release while halted");
   property p_halt_hold;
      halt_out && !(reg_we_in && reg_addr_in == RG_CTRL && reg_wdata_in[0])
      && !$past(reg_we_in && reg_addr_in == RG_CTRL && reg_wdata_in[0]) |=> halt_out;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
   // An accepted call keeps the sequencer busy
   property p_call_runs; call_in && !busy_out && !halt_out |=> busy_out; endproperty
   a_call_runs: assert property (p_call_runs) else $error("call not started");
   property p_rel_pulse; release_out |=> !release_out; endproperty
   a_rel_pulse: assert property (p_rel_pulse) else $error("release too long");
   // No flash pulse may outlive its function
   property p_flash_idle; !busy_out |-> flash_out.op == FL_NONE; endproperty
   a_flash_idle: assert property (p_flash_idle) else $error("flash active when idle");
   // Hidden rows only ever see reads; writes go to the protection row
   property p_hidden;
      flash_out.op inside {FL_PROG_BYTE, FL_ERASE_ROW, FL_ZERO_ROW} && flash_out.addr[13]
      |-> flash_out.addr[12:6] == 7'h00;
   endproperty
   a_hidden: assert property (p_hidden) else $error("hidden row altered");
endmodule : sff_sequencer_properties
`default_nettype wire

// File: verification/sff_sequencer_test.sv
// Self-checking bench for the flash service sequencer.
// SRAM and flash are arrays here; read data stand while the read request stands.
`timescale 1ns/1ps
`default_nettype none
module sff_sequencer_test;
   import sff_pkg::*;
   // Erased flash reads as all ones in this model
   localparam logic [7:0] ERASED = 8'hFF;
   logic           mclk_in, rst_n_in, call_in, release_out, halt_out, busy_out;
   logic           reg_we_in, reg_re_in;
   logic [1:0]     reg_addr_in;
   logic [7:0]     acc_in, sp_in, acc_out, sram_rdata_in, flash_rdata_in, fill;
   logic [7:0]     reg_wdata_in, reg_rdata_out, d;
   sff_sram_req_t  sram_out;
   sff_flash_cmd_t flash_out;
   logic [7:0]     sram [256];
   logic [7:0]     flash [16384];
   int             miscompares = 0;
   int             compares = 0;

   sff_sequencer DUT (.*);

   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end

   // Memories; idle read lines show junk so a late capture never passes
   assign fill = (flash_out.op inside {FL_ZERO_USER, FL_ZERO_ROW}) ? 8'h00 : ERASED;
   assign sram_rdata_in = sram_out.re ? sram[sram_out.addr] : 8'hA5;
   assign flash_rdata_in = (flash_out.op == FL_READ) ? flash[flash_out.addr] : 8'h5A;
   always @(posedge mclk_in) begin
      if (sram_out.we) sram[sram_out.addr] <= sram_out.wdata;
      if (flash_out.op == FL_PROG_BYTE) flash[flash_out.addr] <= flash_out.wdata;
      if (flash_out.op inside {FL_ERASE_USER, FL_ZERO_USER})
         for (int i = 0; i < 8192; i++) flash[i] <= fill;
      if (flash_out.op inside {FL_ERASE_ROW, FL_ZERO_ROW})
         for (int i = 0; i < 64; i++) flash[{flash_out.addr[13:6], 6'(i)}] <= fill;
   end

   task automatic tick;
      @(posedge mclk_in);
      #1;
   endtask : tick

   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One register strobe; read data stand only in the following cycle
   task automatic reg_op(input logic we, input logic [1:0] a, input logic [7:0] wd);
      reg_addr_in <= a;
      reg_wdata_in <= wd;
      reg_we_in <= we;
      reg_re_in <= !we;
      tick;
      reg_we_in <= 1'b0;
      reg_re_in <= 1'b0;
      d = reg_rdata_out;
      tick;
   endtask : reg_op

   // Bounded wait for release or halt, then one cycle for write-backs
   task automatic finish;
      int n;
      n = 0;
      while (!release_out && !halt_out && n < 5000) begin
         tick;
         n++;
      end
      if (n == 5000) begin
         miscompares++;
         print_verdict;
      end
      tick;
   endtask : finish

   // Fill the parameter block, then issue one call; stack pointer is 40h
   task automatic run(input logic [7:0] fn, row, ptr, k1, k2);
      sram[PB_FIRST_GUARD_KEY_AT] = k1;
      sram[PB_SECOND_GUARD_KEY_AT] = k2;
      sram[8'hFA] = row;
      sram[8'hFB] = ptr;
      sram[8'hFC] = 8'h00;
      sram[8'hFE] = 8'h01;
      acc_in <= fn;
      sp_in <= 8'h40;
      call_in <= 1'b1;
      tick;
      call_in <= 1'b0;
      finish;
      $display("call %h finished", fn);
   endtask : run

   task automatic codes(input logic [7:0] k1);
      chk("first key", k1, sram[PB_FIRST_GUARD_KEY_AT]);
      chk("second key", 8'h00, sram[PB_SECOND_GUARD_KEY_AT]);
      chk("accumulator", 8'h00, acc_out);
   endtask : codes

   initial begin
      {rst_n_in, call_in, reg_we_in, reg_re_in, reg_addr_in} = '0;
      {acc_in, sp_in, reg_wdata_in} = '0;
      for (int i = 0; i < 16384; i++) flash[i] = 8'h00;
      for (int i = 0; i < 256; i++) sram[i] = 8'(i);
      // Calibration bytes sum to 0001h, held in the last two bytes
      flash[14'h2040] = 8'h01;
      flash[14'h207E] = 8'h01;
      flash[14'h2001] = 8'h01;
      repeat (10) tick;
      chk("reset acc", 8'h00, acc_out);
      rst_n_in <= 1'b1;
      finish;
      chk("boot halt", 8'h00, {7'h0, halt_out});
      run(FN_PROGRAM, 8'h05, 8'h10, 8'h3A, 8'h43);
      for (int i = 0; i < 64; i++) chk("program", 8'(16 + i), flash[320 + i]);
      run(FN_FETCH, 8'h05, 8'h90, 8'h3A, 8'h43);
      for (int i = 0; i < 64; i++) chk("fetch", 8'(16 + i), sram[144 + i]);
      codes(RC_OK);
      for (int i = 0; i < 64; i++) sram[128 + i] = 8'h00;
      sram[8'h81] = 8'h34;
      run(FN_LOCK, 8'h00, 8'h00, 8'h3A, 8'h43);
      chk("lock byte", 8'h35, flash[14'h2001]);
      run(FN_FETCH, 8'h05, 8'h90, 8'h3A, 8'h43);
      codes(RC_REFUSED);
      run(FN_PROGRAM, 8'h06, 8'h10, 8'h3A, 8'h43);
      codes(RC_REFUSED);
      run(FN_CLEAR, 8'h06, 8'h00, 8'h3A, 8'h43);
      codes(RC_REFUSED);
      reg_op(1'b0, RG_RESULT, 8'h00);
      chk("result", RC_REFUSED, d);
      run(FN_CLEAR, 8'h05, 8'h00, 8'h3A, 8'h43);
      chk("cleared row", ERASED, flash[383]);
      chk("kept level", 8'h35, flash[14'h2001]);
      run(FN_PROGRAM, 8'h05, 8'h80, 8'h3A, 8'h43);
      chk("zeroed row", 8'h00, flash[383]);
      // Bad first key, bad second key, then an unknown function code
      for (int k = 0; k < 3; k++) begin
         run((k == 2) ? 8'h06 : FN_FETCH, 8'h00, 8'h90, (k == 0) ? 8'h3B : 8'h3A,
             (k == 1) ? 8'h42 : 8'h43);
         chk("halted", 8'h01, {7'h0, halt_out});
         reg_op(1'b0, RG_STATUS, 8'h00);
         chk("halt status", 8'h02, d);
         reg_op(1'b1, RG_CTRL, 8'h01);
         tick;
         chk("resumed", 8'h00, {7'h0, halt_out});
      end
      reg_op(1'b0, RG_CTRL, 8'h00);
      chk("ctrl read", 8'h00, d);
      run(FN_WIPE, 8'h00, 8'h00, 8'h3A, 8'h43);
      codes(RC_OK);
      chk("wiped level", 8'h00, flash[14'h2001]);
      chk("wiped user", ERASED, flash[320]);
      chk("hidden row", 8'h01, flash[14'h2040]);
      reg_op(1'b0, RG_LASTFN, 8'h00);
      chk("last function", FN_WIPE, d);
      run(FN_BOOT, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("soft boot", RC_SWBOOT, sram[PB_FIRST_GUARD_KEY_AT]);
      chk("boot halt", 8'h00, {7'h0, halt_out});
      // Corrupt calibration: boot must halt with the fatal code
      flash[14'h2041] = 8'h01;
      run(FN_BOOT, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("fatal code", RC_FATAL, sram[PB_FIRST_GUARD_KEY_AT]);
      chk("fatal halt", 8'h01, {7'h0, halt_out});
      reg_op(1'b0, RG_STATUS, 8'h00);
      chk("fatal status", 8'h06, d);
      print_verdict;
   end
endmodule : sff_sequencer_test

bind sff_sequencer sff_sequencer_properties u_props (.*);
`default_nettype wire
